// *** core/twcp_adapt.sv ***
// adapter end: parity, crc, lrc, read checks and tape mark
`include "twcp_cfg.svh"
module twcp_adapt (
  input wire logic clk_sys_i, // system clock
  input wire logic reset_n_i, // async reset, low
  input wire logic ce_i, // clock enable
  input wire twcp_pkg::twcp_mode_t mode_i, // recording format
  input wire logic head_ready_i, // heads take a character
  output logic [8:0] head_wr_o, // data plus parity to heads
  output logic record_write_pulse_o, // per character strobe
  output logic lrc_pulse_o, // end of record strobe
  input wire logic end_record_i, // write record closes
  input wire logic [8:0] head_rd_i, // read heads, bit 8 parity
  input wire logic head_rd_valid_i, // read character strobe
  input wire logic rd_end_i, // read record closes
  input wire logic [3:0] master_status_i, // master status lines
  input wire logic [3:0] slave_status_i, // slave status lines
  output logic [8:0] crc_o, // running crc
  twcp_link_if.adapt link // controller side
);
  // ------------------------------------------------------------
  // write side
  // ------------------------------------------------------------
  logic [8:0] hw_reg;
  logic rp_reg;
  logic lp_reg;
  logic [8:0] crc_reg;
  logic [7:0] lrc_reg;
  logic [1:0] cnt_reg;
  wire core = (mode_i == twcp_pkg::TWCP_CORE_DUMP);
  wire [7:0] wmask = core ? 8'h3F : 8'hFF;
  wire [7:0] wdat = link.write_data_channels & wmask;
  wire wpar = ^wdat ^ link.odd_parity;
  wire wtake = ce_i && link.wr_valid && head_ready_i;
  wire [8:0] crc_x = crc_reg ^ {wpar, wdat};
  // crc shift with feedback from bit 0, the lowest data position
  wire [8:0] crc_n = {crc_x[0], crc_x[8:1]} ^
    (crc_x[0] ? 9'h03C : 9'h000);
  assign link.wr_ready = head_ready_i;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hw_reg <= '0;
      rp_reg <= 1'b0;
      lp_reg <= 1'b0;
      crc_reg <= '0;
      lrc_reg <= '0;
    end else if (ce_i) begin
      rp_reg <= wtake;
      lp_reg <= end_record_i;
      if (wtake) begin
        hw_reg <= {wpar, wdat};
        crc_reg <= crc_n;
        lrc_reg <= lrc_reg ^ wdat;
      end else if (end_record_i) begin
        hw_reg <= {1'b0, lrc_reg ^ crc_reg[7:0]};
        crc_reg <= '0;
        lrc_reg <= '0;
      end
    end
  end
  // ------------------------------------------------------------
  // read side checks
  // ------------------------------------------------------------
  logic [7:0] rdat_reg;
  logic rpar_reg;
  logic rv_reg;
  logic [7:0] rlrc_reg;
  logic ep_reg;
  logic el_reg;
  logic tm_reg;
  logic [3:0] st_reg;
  logic chg_reg;
  wire rpar_bad = (^head_rd_i) != link.odd_parity;
  wire [3:0] sel_st = link.slave_sel ? slave_status_i : master_status_i;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdat_reg <= '0;
      rpar_reg <= 1'b0;
      rv_reg <= 1'b0;
      rlrc_reg <= '0;
      ep_reg <= 1'b0;
      el_reg <= 1'b0;
      tm_reg <= 1'b0;
      cnt_reg <= '0;
      st_reg <= '0;
      chg_reg <= 1'b0;
    end else if (ce_i) begin
      rv_reg <= head_rd_valid_i && !rd_end_i;
      ep_reg <= head_rd_valid_i && rpar_bad;
      el_reg <= rd_end_i && (rlrc_reg != 8'h00);
      // short record of one character, of any value, is a tape mark
      tm_reg <= rd_end_i && cnt_reg == 2'd1;
      if (head_rd_valid_i) begin
        rdat_reg <= head_rd_i[7:0];
        rpar_reg <= head_rd_i[8];
        rlrc_reg <= rlrc_reg ^ head_rd_i[7:0];
        if (cnt_reg != 2'd3) cnt_reg <= cnt_reg + 2'd1;
      end
      if (rd_end_i) begin
        rlrc_reg <= '0;
        cnt_reg <= '0;
      end
      st_reg <= sel_st;
      chg_reg <= (sel_st != st_reg);
    end
  end
  assign head_wr_o = hw_reg;
  assign record_write_pulse_o = rp_reg;
  assign lrc_pulse_o = lp_reg;
  assign crc_o = crc_reg;
  assign link.read_data_channels = rdat_reg;
  assign link.read_parity_channel = rpar_reg;
  assign link.rd_valid = rv_reg;
  assign link.err_par = ep_reg;
  assign link.err_lrc = el_reg;
  assign link.err_crc = 1'b0;
  assign link.tape_mark = tm_reg;
  assign link.status_chg = chg_reg;
  assign link.xport_status = st_reg;
endmodule : twcp_adapt

// *** core/twcp_cfg.svh ***
// constants for the tape word channel packer
`ifndef TWCP_CFG_SVH
`define TWCP_CFG_SVH
`define TWCP_WORD_W 12
`define TWCP_CHAN_W 8
`define TWCP_HALF_W 6
`define TWCP_FIFO_DEPTH 4
`define TWCP_NINE_LO 4
`define TWCP_ERR_LRC 0
`define TWCP_ERR_CRC 1
`define TWCP_ERR_PAR 2
`define TWCP_ERR_EOF 3
`define TWCP_STAT_W 12
`endif

// *** core/twcp_ctrl.sv ***
// controller end: packs bus words into tape channels and back
// Notes on behaviour
// - nine-channel write sends word bits 4-11
// - core-dump write: two six-bit characters per word
// - core-dump leaves channels 6,7 unused
// - adapter makes parity and crc
// - adapter drives data plus parity channels
// - adapter makes record and lrc pulses
// - adapter checks lrc and parity on read; crc error is tied low, not checked
// - read errors set controller status bits
// - status returned over data bus
// - tape mark reported as end of file
// - nine-channel read takes eight bits plus parity
// - core-dump read holds first character
// - second character completes twelve-bit word
// - adapter reports transport status change at once
// - master or slave transport selectable
// - program selects even or odd parity
// - records at least three characters long
// - lrc makes every track count even; the adapter writes lrc xor crc bits 0-7, with bit 8 zero
`include "twcp_cfg.svh"
module twcp_ctrl #(
  parameter int FIFO_DEPTH = `TWCP_FIFO_DEPTH
) (
  input wire logic clk_sys_i, // system clock
  input wire logic reset_n_i, // async reset, low
  input wire logic ce_i, // clock enable
  input wire twcp_pkg::twcp_mode_t mode_i, // recording format
  input wire logic odd_parity_i, // parity sense select
  input wire logic slave_sel_i, // transport select
  input wire logic [`TWCP_WORD_W-1:0] bus_memory_data_lines_i, // bus word
  input wire logic wr_word_valid_i, // word offered
  output logic wr_word_ready_o, // word accepted
  input wire logic status_rd_i, // status read strobe
  input wire logic status_clr_i, // clear error bits
  output logic [`TWCP_WORD_W-1:0] data_bus_o, // read word or status
  output logic data_valid_o, // data bus valid pulse
  output logic error_flag_o, // any read error held
  output logic eof_o, // tape mark seen
  output logic stat_chg_o, // transport status changed
  twcp_link_if.ctrl link // adapter side
);
  // word and character widths
  localparam int W = `TWCP_WORD_W;
  localparam int H = `TWCP_HALF_W;
  localparam bit DEPTH_BAD = (FIFO_DEPTH < 2) ||
    ((FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0);
  // the fifo pointers wrap by overflow: powers of two only
  if (DEPTH_BAD) begin : g_bad_depth
    $error("twcp_ctrl fifo depth must be a power of two");
  end
  // ------------------------------------------------------------
  // write path
  // ------------------------------------------------------------
  logic [W-1:0] latched_word_bits;
  logic fifo_valid;
  logic fifo_pop;
  logic half_reg;
  logic [`TWCP_CHAN_W-1:0] wd_reg;
  logic wv_reg;
  // words wait here until their characters are taken
  twcp_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .in_data_i(bus_memory_data_lines_i),
    .in_valid_i(wr_word_valid_i),
    .in_ready_o(wr_word_ready_o),
    .out_data_o(latched_word_bits),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );
  // format decode and character slot handshake
  wire core = (mode_i == twcp_pkg::TWCP_CORE_DUMP);
  wire slot_free = !wv_reg || link.wr_ready;
  wire chr_go = ce_i && fifo_valid && slot_free;
  // pop the word in the same cycle its last character is loaded
  assign fifo_pop = slot_free && (!core || half_reg);
  // word positions count from the top bit down, so positions 4 to 11
  // are the low byte and positions 0 to 5 the upper half
  wire [`TWCP_CHAN_W-1:0] nine_chr = latched_word_bits[W-1-`TWCP_NINE_LO -:
    `TWCP_CHAN_W];
  wire [H-1:0] half_bits = half_reg ? latched_word_bits[0 +: H] :
    latched_word_bits[H +: H];
  wire [`TWCP_CHAN_W-1:0] core_chr = {2'b00, half_bits};
  // character register toward the adapter
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wd_reg <= '0;
      wv_reg <= 1'b0;
      half_reg <= 1'b0;
    end else if (ce_i) begin
      if (chr_go) begin
        wd_reg <= core ? core_chr : nine_chr;
        wv_reg <= 1'b1;
        half_reg <= core && !half_reg;
      end else if (link.wr_ready) begin
        wv_reg <= 1'b0;
      end
    end
  end
  // character and its valid go to the adapter
  assign link.write_data_channels = wd_reg;
  assign link.wr_valid = wv_reg;
  // ------------------------------------------------------------
  // selection and parity sense toward adapter
  // ------------------------------------------------------------
  logic odd_reg;
  logic sel_reg;
  // parity sense and transport choice, registered
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      odd_reg <= 1'b1;
      sel_reg <= 1'b0;
    end else if (ce_i) begin
      odd_reg <= odd_parity_i;
      sel_reg <= slave_sel_i;
    end
  end
  // registered choices toward the adapter
  assign link.odd_parity = odd_reg;
  assign link.slave_sel = sel_reg;
  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // read assembly, data bus and sticky status state
  logic [W-1:0] rword_reg;
  logic rhalf_reg;
  logic [W-1:0] dbus_reg;
  logic dval_reg;
  logic [3:0] err_reg;
  logic chg_reg;
  logic eflag_reg;
  wire [W-1:0] nine_word = {{(W-`TWCP_CHAN_W){1'b0}},
    link.read_data_channels};
  // first character held in the upper half, second fills the low half
  wire [W-1:0] core_word = {rword_reg[H-1:0],
    link.read_data_channels[H-1:0]};
  // a word is done on each nine-channel char or second core char
  wire rd_take = ce_i && link.rd_valid;
  wire word_done = rd_take && (!core || rhalf_reg);
  // adapter error strobes in status bit order
  wire [3:0] err_new;
  assign err_new[`TWCP_ERR_LRC] = link.err_lrc;
  assign err_new[`TWCP_ERR_CRC] = link.err_crc;
  assign err_new[`TWCP_ERR_PAR] = link.err_par;
  assign err_new[`TWCP_ERR_EOF] = link.tape_mark;
  // a fresh error beats a clear that falls in the same cycle
  wire [3:0] err_next = (status_clr_i ? 4'h0 : err_reg) | err_new;
  // status: select, parity sense, then the four sticky bits
  wire [W-1:0] status_word = {{(W-6){1'b0}}, sel_reg, odd_reg, err_reg};
  // assembly of read characters
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rword_reg <= '0;
      rhalf_reg <= 1'b0;
    end else if (rd_take) begin
      if (core && !rhalf_reg) begin
        rword_reg <= {{(W-H){1'b0}},
          link.read_data_channels[H-1:0]};
        rhalf_reg <= 1'b1;
      end else begin
        rhalf_reg <= 1'b0;
      end
    end
  end
  // data bus: read word or status
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dbus_reg <= '0;
      dval_reg <= 1'b0;
    end else if (ce_i) begin
      dval_reg <= word_done || status_rd_i;
      if (word_done) dbus_reg <= core ? core_word : nine_word;
      else if (status_rd_i) dbus_reg <= status_word;
      // parity bit is checked by the adapter, flagged via err_par
    end
  end
  // ------------------------------------------------------------
  // sticky status bits
  // ------------------------------------------------------------
  // error and end-of-file bits, and the flag that sums up errors
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      err_reg <= '0;
      eflag_reg <= 1'b0;
    end else if (ce_i) begin
      err_reg <= err_next;
      eflag_reg <= |err_next[`TWCP_ERR_PAR:`TWCP_ERR_LRC];
    end
  end
  // transport status change passed on as a one-cycle pulse
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chg_reg <= 1'b0;
    end else if (ce_i) begin
      chg_reg <= link.status_chg;
    end
  end
  // ------------------------------------------------------------
  // outputs, each straight from a register
  // ------------------------------------------------------------
  assign data_bus_o = dbus_reg;
  assign data_valid_o = dval_reg;
  assign error_flag_o = eflag_reg;
  assign eof_o = err_reg[`TWCP_ERR_EOF];
  assign stat_chg_o = chg_reg;
endmodule : twcp_ctrl

// *** core/twcp_fifo.sv ***
// parameterised valid/ready fifo
module twcp_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys_i, // system clock
  input wire logic reset_n_i, // async reset, low
  input wire logic ce_i, // clock enable
  input wire logic [WIDTH-1:0] in_data_i, // fill data
  input wire logic in_valid_i, // fill valid
  output logic in_ready_o, // room available
  output logic [WIDTH-1:0] out_data_o, // drain data
  output logic out_valid_o, // data available
  input wire logic out_ready_i // drain accepts
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam bit DEPTH_BAD = (DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0);
  // pointers wrap by overflow, so only powers of two are served
  if (DEPTH_BAD) begin : g_bad_depth
    $error("twcp_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic rdy_reg;
  wire push = ce_i && in_valid_i && in_ready_o;
  wire pop = ce_i && out_valid_o && out_ready_i;
  // occupancy after this edge; the room flag is registered from it
  assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready_o = rdy_reg;
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rp_reg];
  // storage
  always_ff @(posedge clk_sys_i) begin
    if (push) mem_reg[wp_reg] <= in_data_i;
  end
  // pointers, count and room flag
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop) rp_reg <= rp_reg + 1'b1;
      cnt_reg <= cnt_next;
      rdy_reg <= (cnt_next != (AW+1)'(DEPTH));
    end
  end
endmodule : twcp_fifo

// *** core/twcp_link_if.sv ***
// channel link between controller and transport adapter
`include "twcp_cfg.svh"
interface twcp_link_if;
  logic [`TWCP_CHAN_W-1:0] write_data_channels;
  logic wr_valid;
  logic wr_ready;
  logic [`TWCP_CHAN_W-1:0] read_data_channels;
  logic read_parity_channel;
  logic rd_valid;
  logic err_lrc;
  logic err_crc;
  logic err_par;
  logic tape_mark;
  logic odd_parity;
  logic slave_sel;
  logic status_chg;
  logic [3:0] xport_status;
  modport ctrl (
    output write_data_channels, wr_valid, odd_parity, slave_sel,
    input wr_ready, read_data_channels, read_parity_channel, rd_valid,
    input err_lrc, err_crc, err_par, tape_mark, status_chg, xport_status
  );
  modport adapt (
    input write_data_channels, wr_valid, odd_parity, slave_sel,
    output wr_ready, read_data_channels, read_parity_channel, rd_valid,
    output err_lrc, err_crc, err_par, tape_mark, status_chg, xport_status
  );
endinterface : twcp_link_if

// *** core/twcp_pkg.sv ***
// types shared by both ends of the tape word channel packer
package twcp_pkg;
  typedef enum logic {
    TWCP_NINE_CHAN,
    TWCP_CORE_DUMP
  } twcp_mode_t;
endpackage : twcp_pkg

// *** tb/tape_word_channel_packer_tb_top.sv ***
// self-checking bench for both packer ends joined by the link
`include "twcp_cfg.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
`define WAIT(c, lim) begin wn = 0; while (!(c) && wn < lim) begin \
  @(posedge clk_sys_i); #1; wn++; end end
`define PULSE(s) begin s = 1'b1; @(posedge clk_sys_i); #1; s = 1'b0; \
  @(posedge clk_sys_i); #1; end
module tape_word_channel_packer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0;
  twcp_pkg::twcp_mode_t mode = twcp_pkg::TWCP_NINE_CHAN;
  logic odd_par = 1'b1, sel = 1'b0, wvalid = 1'b0, srd = 1'b0, sclr = 1'b0;
  logic hold_off = 1'b1, head_ready = 1'b0, end_rec = 1'b0, rd_end = 1'b0;
  logic head_rd_valid = 1'b0, wready, dvalid, eflag, eof, schg, rec_p, lrc_p;
  logic [11:0] word = 12'h000, dbus, exp_w;
  logic [8:0] head_rd = 9'h000, head_wr;
  logic [7:0] exp_c;
  logic [3:0] mst = 4'h0, slv = 4'h0;
  logic [7:0] wr_q[$];
  logic [11:0] rd_q[$];
  int err_count = 0, checks = 0, wn, k, lrc_cnt = 0;
  twcp_link_if link ();
  twcp_ctrl #(.FIFO_DEPTH(`TWCP_FIFO_DEPTH)) i_twcp_ctrl (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .mode_i(mode),
    .odd_parity_i(odd_par), .slave_sel_i(sel), .bus_memory_data_lines_i(word),
    .wr_word_valid_i(wvalid), .wr_word_ready_o(wready), .status_rd_i(srd),
    .status_clr_i(sclr), .data_bus_o(dbus), .data_valid_o(dvalid),
    .error_flag_o(eflag), .eof_o(eof), .stat_chg_o(schg), .link(link));
  twcp_adapt i_twcp_adapt (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .mode_i(mode),
    .head_ready_i(head_ready), .head_wr_o(head_wr), .record_write_pulse_o(rec_p),
    .lrc_pulse_o(lrc_p), .end_record_i(end_rec), .head_rd_i(head_rd),
    .head_rd_valid_i(head_rd_valid), .rd_end_i(rd_end), .master_status_i(mst),
    .slave_status_i(slv), .crc_o(), .link(link));
  twcp_link_props i_twcp_link_props (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .mode_i(mode),
    .write_data_channels(link.write_data_channels), .wr_valid(link.wr_valid),
    .wr_ready(link.wr_ready), .read_data_channels(link.read_data_channels),
    .read_parity_channel(link.read_parity_channel), .rd_valid(link.rd_valid),
    .err_crc(link.err_crc), .err_par(link.err_par), .tape_mark(link.tape_mark),
    .odd_parity(link.odd_parity), .slave_sel(link.slave_sel),
    .status_chg(link.status_chg), .xport_status(link.xport_status));
  // ----------------------------------------------------------------
  // clock, head stalls and scoreboards
  // ----------------------------------------------------------------
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    #1;
    head_ready = hold_off ? 1'b0 : 1'($urandom_range(1));
  end
  always @(posedge clk_sys_i) begin
    if (link.wr_valid === 1'b1 && link.wr_ready === 1'b1) begin
      exp_c = wr_q.size() ? wr_q.pop_front() : 8'hxx;
      `CHK(link.write_data_channels, exp_c)
    end
    if (rec_p === 1'b1) `CHK(^head_wr, odd_par)
    if (lrc_p === 1'b1) lrc_cnt++;
    if (dvalid === 1'b1) begin
      exp_w = rd_q.size() ? rd_q.pop_front() : 12'hxxx;
      `CHK(dbus, exp_w)
    end
  end
  // expected tape character of a word, by format
  function automatic logic [7:0] exp_char(input logic [11:0] w, input bit hi);
    if (mode == twcp_pkg::TWCP_NINE_CHAN) return w[7:0];
    return hi ? {2'b00, w[5:0]} : {2'b00, w[11:6]};
  endfunction : exp_char
  task automatic put_word(input logic [11:0] w);
    word = w;
    wvalid = 1'b1;
    wr_q.push_back(exp_char(w, 1'b0));
    if (mode == twcp_pkg::TWCP_CORE_DUMP) wr_q.push_back(exp_char(w, 1'b1));
    `WAIT(wready === 1'b1, 200)
    @(posedge clk_sys_i);
    #1;
  endtask : put_word
  task automatic rd_char(input logic [7:0] d, input logic bad);
    head_rd = {(^d) ^ odd_par ^ bad, d};
    `PULSE(head_rd_valid)
  endtask : rd_char
  // record whose tracks sum even; the first nbad chars carry bad parity
  task automatic rd_record(input int nbad);
    logic [7:0] c[4];
    logic [7:0] acc;
    int len;
    len = (mode == twcp_pkg::TWCP_NINE_CHAN) ? 3 : 4;
    acc = 8'h00;
    for (int i = 0; i < len; i++) begin
      c[i] = (i == len - 1) ? acc : 8'($urandom) & (len == 3 ? 8'hff : 8'h3f);
      acc ^= c[i];
      if (len == 3) rd_q.push_back({4'h0, c[i]});
      else if (i[0]) rd_q.push_back({c[i-1][5:0], c[i][5:0]});
      rd_char(c[i], i < nbad);
    end
    `PULSE(rd_end)
    `WAIT(rd_q.size() == 0, 40)
  endtask : rd_record
  task automatic rd_status(input logic par, input logic mark);
    rd_q.push_back({6'h00, sel, odd_par, mark, par, 2'b00});
    `PULSE(srd)
    `WAIT(rd_q.size() == 0, 10)
  endtask : rd_status
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #400000; // far beyond the few hundred cycles the tests need
    err_count++;
    report_and_stop;
  end
  initial begin
    void'($urandom(67633));
    repeat (16) @(posedge clk_sys_i);
    #1;
    reset_n_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    rd_status(1'b0, 1'b0);
    $display("test reset done");
    for (int m = 0; m < 2; m++) begin
      mode = twcp_pkg::twcp_mode_t'(m[0]);
      odd_par = 1'($urandom_range(1));
      hold_off = 1'b1;
      for (k = 0; k < 12 && wready === 1'b1; k++) begin
        put_word(k == 0 ? 12'hfff : 12'($urandom));
      end
      wvalid = 1'b0;
      `CHK(k >= `TWCP_FIFO_DEPTH, 1'b1)
      `CHK(wready, 1'b0)
      hold_off = 1'b0;
      for (k = 0; k < 20; k++) put_word(12'($urandom));
      wvalid = 1'b0;
      `WAIT(wr_q.size() == 0, 400)
      `CHK(wr_q.size(), 0)
      `PULSE(end_rec)
      `WAIT(lrc_cnt == m + 1, 20)
      `CHK(lrc_cnt, m + 1)
      odd_par = 1'b0;
      // let the registered parity sense settle before reading
      @(posedge clk_sys_i);
      #1;
      rd_record(0);
      `CHK(eflag, 1'b0)
      $display("test mode %0d done", m);
    end
    rd_record(2);
    `WAIT(eflag === 1'b1, 20)
    `CHK(eflag, 1'b1)
    rd_status(1'b1, 1'b0);
    `PULSE(sclr)
    `CHK(eflag, 1'b0)
    rd_status(1'b0, 1'b0);
    $display("test parity error done");
    mst = 4'h5;
    `WAIT(schg === 1'b1, 8)
    `CHK(schg, 1'b1)
    // let the pulse of the master change die away first
    repeat (4) @(posedge clk_sys_i);
    #1;
    slv = 4'h3;
    `WAIT(schg === 1'b1, 8)
    `CHK(schg, 1'b0)
    sel = 1'b1;
    repeat (8) @(posedge clk_sys_i);
    #1;
    slv = 4'h6;
    `WAIT(schg === 1'b1, 8)
    `CHK(schg, 1'b1)
    rd_status(1'b0, 1'b0);
    $display("test status change done");
    mode = twcp_pkg::TWCP_NINE_CHAN;
    rd_q.push_back(12'h000);
    rd_char(8'h00, 1'b0);
    `PULSE(rd_end)
    `WAIT(eof === 1'b1, 20)
    `CHK(eof, 1'b1)
    rd_status(1'b0, 1'b1);
    $display("test tape mark done");
    report_and_stop;
  end
endmodule : tape_word_channel_packer_tb_top

// *** tb/twcp_link_props.sv ***
// checker on the controller to adapter link signals
`include "twcp_cfg.svh"
module twcp_link_props (
  input wire logic clk_sys_i, // system clock
  input wire logic reset_n_i, // async reset, low
  input wire twcp_pkg::twcp_mode_t mode_i, // recording format
  input wire logic [`TWCP_CHAN_W-1:0] write_data_channels, // write chars
  input wire logic wr_valid, // char offered
  input wire logic wr_ready, // char taken
  input wire logic [`TWCP_CHAN_W-1:0] read_data_channels, // read chars
  input wire logic read_parity_channel, // read parity
  input wire logic rd_valid, // read char strobe
  input wire logic err_crc, // crc error
  input wire logic err_par, // parity error
  input wire logic tape_mark, // tape mark seen
  input wire logic odd_parity, // parity sense
  input wire logic slave_sel, // transport select
  input wire logic status_chg, // status changed
  input wire logic [3:0] xport_status // selected status
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  logic [3:0] idle_cnt_reg;
  logic [3:0] idle_cnt_next;
  // ----------------------------------------------------------------
  // cycles since the last read character, saturating
  // ----------------------------------------------------------------
  assign idle_cnt_next = (idle_cnt_reg == 4'hf) ? 4'hf : idle_cnt_reg + 4'h1;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) idle_cnt_reg <= 4'hf;
    else idle_cnt_reg <= rd_valid ? 4'h0 : idle_cnt_next;
  end
  a_wr_hold_valid: assert property (wr_valid && !wr_ready |=> wr_valid)
    else $error("write char withdrawn before accept");
  a_wr_hold_data: assert property (wr_valid && !wr_ready |=>
    $stable(write_data_channels)) else $error("write char changed waiting");
  a_wr_drop_late: assert property ($fell(wr_valid) |-> $past(wr_ready))
    else $error("write valid fell without accept");
  a_core_upper_idle: assert property (mode_i == twcp_pkg::TWCP_CORE_DUMP
    && wr_valid |-> write_data_channels[7:6] == 2'b00)
    else $error("channels six and seven used in core dump");
  a_par_bad_flag: assert property (rd_valid && ((^{read_parity_channel,
    read_data_channels}) != odd_parity) |-> ##[0:2] err_par)
    else $error("bad parity char not flagged");
  a_crc_flag_quiet: assert property (!err_crc)
    else $error("crc error raised while unchecked");
  a_stat_change_report: assert property ($changed(xport_status) &&
    $stable(slave_sel) |-> ##[0:2] status_chg)
    else $error("transport status change not reported");
  a_mark_after_char: assert property ($rose(tape_mark) |->
    idle_cnt_reg >= 4'h1 && idle_cnt_reg <= 4'h8)
    else $error("tape mark without a preceding character");
  c_wr_accept: cover property (wr_valid && wr_ready);
  c_par_flag: cover property ($rose(err_par));
  c_mark: cover property ($rose(tape_mark));
  c_stat_chg: cover property (status_chg);
endmodule : twcp_link_props
